// ==== rtl/snooze_wake_pkg.sv ====
// Purpose : shared constants for the snooze, chirp and resume sequencer
// Assumes : 25 MHz system clock, UTMI style transceiver controls
// Notes   : register map, field positions and timing counts live here only
package snooze_wake_pkg;

   // **********
   // register map (byte addresses, one 32-bit word each)
   // **********
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_FLAGS  = 4'h4;
   localparam logic [3:0] ADDR_ENABLE = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hc;

   // control register bits
   localparam int CTRL_GO_ACTIVE   = 0;
   localparam int CTRL_GO_SNOOZE   = 1;
   localparam int CTRL_BUS_DET_DIS = 2;
   localparam int CTRL_CHIRP       = 3;
   localparam int CTRL_SEND_RESUME = 4;
   localparam int CTRL_RESTORE     = 5;

   // flag register bits (write one to clear)
   localparam int FLAG_LINE_ACT    = 0;
   localparam int FLAG_CHIRP_CMP   = 1;
   localparam int FLAG_RESTORE_CMP = 2;

   // enable register bits
   localparam int EN_LINE_ACT      = 0;
   localparam int EN_CHIRP_CMP     = 1;
   localparam int EN_RESTORE_CMP   = 2;
   localparam int EN_SIE_GROUP     = 3;
   localparam int EN_MAIN          = 4;

   // status register fields
   localparam int ST_PM_LSB        = 0;
   localparam int ST_LINE_LSB      = 3;
   localparam int ST_SAVED_SPEED   = 5;
   localparam int ST_XCVR          = 6;
   localparam int ST_TERM          = 7;
   localparam int ST_TRANSCEIVER_OPERATING_SELECT_LSB    = 8;

   // power state field codes
   localparam logic [2:0] PM_CODE_ACTIVE  = 3'h0;
   localparam logic [2:0] PM_CODE_SNOOZE  = 3'h1;
   localparam logic [2:0] PM_CODE_PLL     = 3'h2;

   // **********
   // line and transceiver encodings
   // **********
   localparam logic [1:0] LINE_SE0   = 2'h0;
   localparam logic [1:0] LINE_J     = 2'h1;
   localparam logic [1:0] LINE_K     = 2'h2;
   localparam logic       SPEED_HS   = 1'b0;
   localparam logic       SPEED_FS   = 1'b1;
   localparam logic [1:0] OPM_NORMAL = 2'h0;
   localparam logic [1:0] OPM_NOSTUF = 2'h2;
   localparam logic [2:0] KJ_NEEDED  = 3'h6;

   // **********
   // timing
   // **********
   localparam longint CLK_HZ        = 25_000_000;
   localparam longint PLL_UP_NS     = 250_000;
   localparam longint CHIRP_CYC_60M = 66_000;
   localparam longint INT_CLK_HZ    = 60_000_000;
   localparam int     PLL_CYCLES    = int'((PLL_UP_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
   localparam int     CHIRP_CYCLES  = int'((CHIRP_CYC_60M * CLK_HZ + INT_CLK_HZ - 1) / INT_CLK_HZ);

   typedef enum logic [1:0] {PWR_ACTIVE, PWR_SNOOZE, PWR_PLL_WAIT} pwr_e;
   typedef enum logic [1:0] {CH_IDLE, CH_TX, CH_LISTEN} chirp_e;

endpackage

// ==== rtl/line_mon_if.sv ====
// Purpose : carries the filtered line level and chirp alternation count
// Assumes : single clock domain
// Notes   : mon drives level and kj_count, ctl drives count_clr
`timescale 1ns/1ps
interface line_mon_if;
   logic [1:0] level;
   logic [2:0] kj_count;
   logic       count_clr;
   modport mon (output level, output kj_count, input count_clr);
   modport ctl (input level, input kj_count, output count_clr);
endinterface

// ==== rtl/line_monitor.sv ====
// Purpose : synchronises the bus line level and counts chirp K/J alternations
// Assumes : line level pins are asynchronous to clk_i
// Notes   : a change is accepted once the second and third stages agree
`timescale 1ns/1ps
module line_monitor
   import snooze_wake_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  rst_n_i,
   input  wire logic  ce_i,
   input  wire logic [1:0] line_i,
   line_mon_if.mon    lm
);
   logic [1:0] sync1_ff, sync2_ff, sync3_ff, level_ff, last_ff;
   logic [2:0] count_ff;

   // **********
   // three stage synchroniser and agreement filter
   // **********
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_ff <= LINE_J;
         sync2_ff <= LINE_J;
         sync3_ff <= LINE_J;
         level_ff <= LINE_J;
      end else if (ce_i) begin
         sync1_ff <= line_i;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         if (sync2_ff == sync3_ff) begin
            level_ff <= sync3_ff;
         end
      end
   end

   // **********
   // chirp alternation counter, saturating
   // **********
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_ff <= 3'h0;
         last_ff  <= LINE_J;
      end else if (ce_i) begin
         if (lm.count_clr) begin
            count_ff <= 3'h0;
            last_ff  <= LINE_J;
         end else if ((level_ff == LINE_K || level_ff == LINE_J) && level_ff != last_ff) begin
            last_ff <= level_ff;
            if (count_ff != 3'h7) begin
               count_ff <= count_ff + 3'h1;
            end
         end
      end
   end

   assign lm.level    = level_ff;
   assign lm.kj_count = count_ff;
endmodule

// ==== rtl/snooze_wake_ctrl.sv ====
// Purpose : snooze exit, chirp handshake and remote wakeup resume sequencing
// Assumes : Avalon-MM slave with waitrequest, 25 MHz clk_i, ce_i freezes all but the reset release
// Notes   : flags are write-one-to-clear, a hardware set wins over a clear
`timescale 1ns/1ps
module snooze_wake_ctrl
   import snooze_wake_pkg::*;
#(
   parameter int PLL_WAIT_CYC  = PLL_CYCLES,
   parameter int CHIRP_TX_CYC  = CHIRP_CYCLES
)(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        ce_i,
   input  wire logic [3:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   input  wire logic [1:0]  line_level_i,
   output logic             int_clk_en_o,
   output logic             interrupt_out_n_o,
   output logic             transceiver_speed_select_o,
   output logic             termination_select_o,
   output logic [1:0]       transceiver_operating_select_o,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   output logic             bus_detect_disable_o
);
   logic        rst_a_ff, rst_n;
   logic        wait_ff;
   logic [31:0] rdata_ff;
   pwr_e        pwr_ff;
   chirp_e      ch_ff;
   logic [15:0] timer_ff;
   logic [15:0] timer_ch_ff;
   logic        go_active_ff, bus_det_dis_ff, chirp_req_ff, send_resume_ff, restore_ff;
   logic        line_act_ff, chirp_cmp_ff, restore_cmp_ff;
   logic [4:0]  enable_ff;
   logic        saved_speed_ff, xcvr_ff, term_ff;
   logic        irq_n_ff, clk_en_ff, tx_valid_ff;
   logic [1:0]  transceiver_operating_select_ff;
   logic        nxt_line_act, nxt_chirp_cmp, nxt_restore_cmp;
   logic        set_line_act, set_chirp_cmp, set_restore_cmp;
   logic        wr_ok, wr_ctrl, wr_flags;
   line_mon_if  lm ();

   function automatic logic hit(input logic [3:0] a, input logic [3:0] base);
      return a == base;
   endfunction

   function automatic logic timer_ch_done(input logic [15:0] t);
      return t <= 16'h1;
   endfunction

   // **********
   // reset release and line monitor
   // **********
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_a_ff <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_a_ff <= 1'b1;
         rst_n    <= rst_a_ff;
      end
   end

   line_monitor u_mon (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .ce_i    (ce_i),
      .line_i  (line_level_i),
      .lm      (lm.mon)
   );

   assign lm.count_clr = (ch_ff != CH_LISTEN);

   // **********
   // avalon slave: one wait cycle, write lands when waitrequest is low
   // **********
   assign wr_ok    = write_i && !wait_ff && byteenable_i[0];
   assign wr_ctrl  = wr_ok && hit(address_i, ADDR_CTRL);
   assign wr_flags = wr_ok && hit(address_i, ADDR_FLAGS);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0;
      end else if (ce_i) begin
         wait_ff <= !((read_i || write_i) && wait_ff);
         if (read_i && wait_ff) begin
            rdata_ff <= 32'h0;
            unique case (1'b1)
               hit(address_i, ADDR_CTRL): rdata_ff[5:0] <= {restore_ff, send_resume_ff, chirp_req_ff,
                                                            bus_det_dis_ff, 1'b0, go_active_ff};
               hit(address_i, ADDR_FLAGS): rdata_ff[2:0] <= {restore_cmp_ff, chirp_cmp_ff, line_act_ff};
               hit(address_i, ADDR_ENABLE): rdata_ff[4:0] <= enable_ff;
               hit(address_i, ADDR_STATUS): begin
                  rdata_ff[ST_PM_LSB +: 3]     <= (pwr_ff == PWR_ACTIVE) ? PM_CODE_ACTIVE :
                                                  (pwr_ff == PWR_SNOOZE) ? PM_CODE_SNOOZE : PM_CODE_PLL;
                  rdata_ff[ST_LINE_LSB +: 2]   <= lm.level;
                  rdata_ff[ST_SAVED_SPEED]     <= saved_speed_ff;
                  rdata_ff[ST_XCVR]            <= xcvr_ff;
                  rdata_ff[ST_TERM]            <= term_ff;
                  rdata_ff[ST_TRANSCEIVER_OPERATING_SELECT_LSB +: 2] <= transceiver_operating_select_ff;
               end
               default: rdata_ff <= 32'h0; // unmapped reads zero
            endcase
         end
      end
   end

   // **********
   // power state: snooze, PLL wait, active
   // **********
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pwr_ff       <= PWR_ACTIVE;
         go_active_ff <= 1'b0;
         timer_ff     <= 16'h0;
      end else if (ce_i) begin
         if (wr_ctrl && writedata_i[CTRL_GO_ACTIVE] && pwr_ff != PWR_ACTIVE) begin
            go_active_ff <= 1'b1;
         end
         unique case (pwr_ff)
            PWR_ACTIVE: begin
               if (wr_ctrl && writedata_i[CTRL_GO_SNOOZE]) begin
                  pwr_ff <= PWR_SNOOZE;
               end
            end
            PWR_SNOOZE: begin
               if (go_active_ff) begin
                  pwr_ff   <= PWR_PLL_WAIT;
                  timer_ff <= 16'(PLL_WAIT_CYC);
               end
            end
            PWR_PLL_WAIT: begin
               if (timer_ff <= 16'h1) begin
                  pwr_ff       <= PWR_ACTIVE;
                  go_active_ff <= 1'b0;
               end else begin
                  timer_ff <= timer_ff - 16'h1;
               end
            end
         endcase
      end
   end

   // **********
   // chirp handshake and resume drive
   // **********
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ch_ff          <= CH_IDLE;
         chirp_req_ff   <= 1'b0;
         send_resume_ff <= 1'b0;
         bus_det_dis_ff <= 1'b0;
         restore_ff     <= 1'b0;
         xcvr_ff        <= SPEED_FS;
         term_ff        <= SPEED_FS;
         saved_speed_ff <= SPEED_FS;
         set_chirp_cmp  <= 1'b0;
         set_restore_cmp <= 1'b0;
      end else if (ce_i) begin
         set_chirp_cmp   <= 1'b0;
         set_restore_cmp <= 1'b0;
         if (wr_ctrl) begin
            bus_det_dis_ff <= writedata_i[CTRL_BUS_DET_DIS];
            send_resume_ff <= writedata_i[CTRL_SEND_RESUME];
            if (writedata_i[CTRL_CHIRP]) begin
               chirp_req_ff <= 1'b1;
            end
            if (writedata_i[CTRL_RESTORE]) begin
               restore_ff <= 1'b1;
            end
            if (writedata_i[CTRL_GO_SNOOZE] && pwr_ff == PWR_ACTIVE) begin
               saved_speed_ff <= xcvr_ff;
            end
         end
         unique case (ch_ff)
            CH_IDLE: begin
               if (chirp_req_ff && pwr_ff == PWR_ACTIVE) begin
                  ch_ff   <= CH_TX;
                  xcvr_ff <= SPEED_HS;
               end
            end
            CH_TX: begin
               if (timer_ch_done(timer_ch_ff)) begin
                  ch_ff <= CH_LISTEN;
               end
            end
            CH_LISTEN: begin
               if (lm.kj_count >= KJ_NEEDED) begin
                  ch_ff          <= CH_IDLE;
                  term_ff        <= SPEED_HS;
                  chirp_req_ff   <= 1'b0;
                  saved_speed_ff <= SPEED_HS;
                  set_chirp_cmp  <= 1'b1;
               end
            end
         endcase
         if (restore_ff && !send_resume_ff && lm.level != LINE_K) begin
            xcvr_ff         <= saved_speed_ff;
            term_ff         <= saved_speed_ff;
            restore_ff      <= 1'b0;
            set_restore_cmp <= 1'b1;
         end
      end
   end

   // chirp duration counter
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         timer_ch_ff <= 16'h0;
      end else if (ce_i) begin
         if (ch_ff != CH_TX) begin
            timer_ch_ff <= 16'(CHIRP_TX_CYC);
         end else if (!timer_ch_done(timer_ch_ff)) begin
            timer_ch_ff <= timer_ch_ff - 16'h1;
         end
      end
   end

   // **********
   // sticky flags, set wins over clear, and interrupt
   // **********
   assign set_line_act    = (pwr_ff == PWR_SNOOZE) && (lm.level != LINE_J);
   assign nxt_line_act    = set_line_act || (line_act_ff && !(wr_flags && writedata_i[FLAG_LINE_ACT]));
   assign nxt_chirp_cmp   = set_chirp_cmp || (chirp_cmp_ff && !(wr_flags && writedata_i[FLAG_CHIRP_CMP]));
   assign nxt_restore_cmp = set_restore_cmp ||
                            (restore_cmp_ff && !(wr_flags && writedata_i[FLAG_RESTORE_CMP]));

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         line_act_ff    <= 1'b0;
         chirp_cmp_ff   <= 1'b0;
         restore_cmp_ff <= 1'b0;
         enable_ff      <= 5'h0;
         irq_n_ff       <= 1'b1;
      end else if (ce_i) begin
         line_act_ff    <= nxt_line_act;
         chirp_cmp_ff   <= nxt_chirp_cmp;
         restore_cmp_ff <= nxt_restore_cmp;
         if (wr_ok && hit(address_i, ADDR_ENABLE)) begin
            enable_ff <= writedata_i[4:0];
         end
         irq_n_ff <= !(enable_ff[EN_MAIN] && enable_ff[EN_SIE_GROUP] &&
                       ((nxt_line_act && enable_ff[EN_LINE_ACT]) ||
                        (nxt_chirp_cmp && enable_ff[EN_CHIRP_CMP]) ||
                        (nxt_restore_cmp && enable_ff[EN_RESTORE_CMP])));
      end
   end

   // **********
   // transceiver drive and clock gate registers
   // **********
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         transceiver_operating_select_ff   <= OPM_NORMAL;
         tx_valid_ff <= 1'b0;
         clk_en_ff   <= 1'b0;
      end else if (ce_i) begin
         clk_en_ff   <= (pwr_ff == PWR_ACTIVE);
         tx_valid_ff <= send_resume_ff || (ch_ff == CH_TX);
         transceiver_operating_select_ff   <= (send_resume_ff || ch_ff == CH_TX) ? OPM_NOSTUF : OPM_NORMAL;
      end
   end

   assign readdata_o                     = rdata_ff;
   assign waitrequest_o                  = wait_ff;
   assign int_clk_en_o                   = clk_en_ff;
   assign interrupt_out_n_o              = irq_n_ff;
   assign transceiver_speed_select_o     = xcvr_ff;
   assign termination_select_o           = term_ff;
   assign transceiver_operating_select_o = transceiver_operating_select_ff;
   assign tx_valid_o                     = tx_valid_ff;
   assign tx_data_o                      = 8'h00; // raw zero data drives K
   assign bus_detect_disable_o           = bus_det_dis_ff;
endmodule

// ==== dv/usb_port_model.sv ====
// Purpose : behavioural downstream port that drives the bus line level
// Assumes : mode_i picks idle J, bus reset, chirp reply or resume echo
// Notes   : every time is a scaled count of clk_i cycles
`timescale 1ns/1ps
module usb_port_model
   import snooze_wake_pkg::*;
#(
   parameter int KJ_HOLD = 8,
   parameter int ECHO    = 10,
   parameter int K_HOLD  = 200,
   parameter int EOP     = 33
)(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       tx_valid_i,
   output logic      [1:0] line_o
);
   int   cnt;
   int   step;
   logic tx_d;
   // **********
   // line driver, the device's own K shows on the line while it sends in chirp reply and resume echo modes, outside the reply levels
   // **********
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         line_o <= LINE_J;
         cnt    <= 0;
         step   <= 0;
         tx_d   <= 1'b0;
      end else begin
         tx_d <= tx_valid_i;
         cnt  <= cnt + 1;
         if (mode_i < 2'd2) begin
            step   <= 0;
            cnt    <= 0;
            line_o <= mode_i[0] ? LINE_SE0 : LINE_J;
         end else if (mode_i == 2'd2) begin
            // chirp reply: twelve K/J levels after the device chirp ends
            if (step == 0 && tx_d && !tx_valid_i) begin
               step <= 1;
               cnt  <= 0;
            end else if (step > 0 && step < 14 && cnt >= KJ_HOLD) begin
               step <= step + 1;
               cnt  <= 0;
            end
            line_o <= (step >= 2 && step < 14) ? (step[0] ? LINE_J : LINE_K) : (tx_valid_i ? LINE_K : LINE_SE0);
         end else begin
            // resume echo, then end of K with a two bit SE0
            if (step == 0 && !tx_valid_i) begin
               cnt <= 0;
            end else if (step == 0 && cnt >= ECHO) begin
               step <= 1;
               cnt  <= 0;
            end else if ((step == 1 && cnt >= K_HOLD) || (step == 2 && cnt >= EOP)) begin
               step <= step + 1;
               cnt  <= 0;
            end
            line_o <= (step == 1 || tx_valid_i) ? LINE_K : ((step == 2) ? LINE_SE0 : LINE_J);
         end
      end
   end
endmodule

// ==== dv/snooze_wake_ctrl_asserts.sv ====
// Purpose : port level checks of snooze exit, chirp and resume sequencing
// Assumes : sees only the top ports, shadows what firmware wrote
// Notes   : ce_i is expected high while the shadows are meaningful
`timescale 1ns/1ps
module snooze_wake_ctrl_asserts
   import snooze_wake_pkg::*;
#(
   parameter int PLL_WAIT_CYC = 10,
   parameter int CHIRP_TX_CYC = 20
)(
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        ce_i,
   input wire logic [3:0]  address_i,
   input wire logic        write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0]  byteenable_i,
   input wire logic        waitrequest_o,
   input wire logic [1:0]  line_level_i,
   input wire logic        int_clk_en_o,
   input wire logic        interrupt_out_n_o,
   input wire logic        transceiver_speed_select_o,
   input wire logic        termination_select_o,
   input wire logic [1:0]  transceiver_operating_select_o,
   input wire logic        tx_valid_o,
   input wire logic [7:0]  tx_data_o
);
   logic [4:0]  en_ff;
   logic        sno_ff, snd_ff, rs_ff, pend_ff;
   logic [31:0] pll_cnt_ff, tx_cnt_ff;
   logic        wr_done, ctrl_wr;
   assign wr_done = write_i && !waitrequest_o && ce_i && byteenable_i[0];
   assign ctrl_wr = wr_done && address_i == ADDR_CTRL;
   // **********
   // shadow of firmware writes and cycle counters
   // **********
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {en_ff, sno_ff, snd_ff, rs_ff, pend_ff} <= '0;
      end else begin
         if (wr_done && address_i == ADDR_ENABLE) en_ff <= writedata_i[4:0];
         if (ctrl_wr) begin
            sno_ff <= writedata_i[CTRL_GO_SNOOZE] || (sno_ff && !writedata_i[CTRL_GO_ACTIVE]);
            snd_ff <= writedata_i[CTRL_SEND_RESUME];
            rs_ff  <= writedata_i[CTRL_RESTORE];
         end
         pend_ff <= int_clk_en_o ? 1'b0 : (pend_ff || (ctrl_wr && writedata_i[CTRL_GO_ACTIVE]));
      end
   end
   // counts the PLL wait and the length of each transmit burst
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pll_cnt_ff <= '0;
         tx_cnt_ff  <= '0;
      end else begin
         pll_cnt_ff <= pend_ff ? pll_cnt_ff + 1 : '0;
         tx_cnt_ff  <= tx_valid_o ? tx_cnt_ff + 1 : '0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   AST_NO_CLK_IN_SNOOZE: assert property (sno_ff && $past(sno_ff) |-> !int_clk_en_o)
      else $error("internal clock enabled in snooze");
   AST_PLL_TIME: assert property ($rose(int_clk_en_o) && pend_ff |->
      pll_cnt_ff >= PLL_WAIT_CYC - 1 && pll_cnt_ff <= PLL_WAIT_CYC + 3) else $error("PLL wait length wrong");
   AST_LINE_ACT_IRQ: assert property ((ce_i && sno_ff && (en_ff & 5'h19) == 5'h19 && line_level_i != LINE_J) [*8]
      |-> !interrupt_out_n_o) else $error("line activity not signalled");
   AST_IRQ_NEEDS_MAIN: assert property (!interrupt_out_n_o |->
      $past(en_ff[EN_MAIN]) && $past(en_ff[EN_SIE_GROUP])) else $error("interrupt without group enables");
   AST_IRQ_HELD: assert property (!interrupt_out_n_o && !wr_done && !$past(wr_done) |=> !interrupt_out_n_o)
      else $error("interrupt dropped while pending");
   AST_RESUME_TX: assert property (snd_ff && $past(snd_ff) |-> tx_valid_o)
      else $error("no resume transmit");
   AST_TX_RAW: assert property (tx_valid_o |-> tx_data_o == 8'h00 && transceiver_operating_select_o == OPM_NOSTUF)
      else $error("transmit not raw zero data");
   AST_CHIRP_LEN: assert property ($fell(tx_valid_o) && !$past(snd_ff, 2) |-> tx_cnt_ff == CHIRP_TX_CYC)
      else $error("chirp length wrong");
   AST_TERM_WITH_XCVR: assert property ($fell(termination_select_o) |-> transceiver_speed_select_o == SPEED_HS)
      else $error("HS termination without HS transceiver");
   AST_RESTORE_DONE: assert property (rs_ff && !snd_ff && (en_ff & 5'h1c) == 5'h1c && $past(line_level_i) == LINE_K
      && line_level_i != LINE_K |-> ##[1:12] (!interrupt_out_n_o && transceiver_speed_select_o == termination_select_o))
      else $error("restore not completed in time");
   COV_IRQ: cover property ($fell(interrupt_out_n_o));
   COV_ACTIVE: cover property ($rose(int_clk_en_o) && pend_ff);
   COV_HS_TERM: cover property ($fell(termination_select_o));
endmodule
bind snooze_wake_ctrl snooze_wake_ctrl_asserts #(.PLL_WAIT_CYC(PLL_WAIT_CYC), .CHIRP_TX_CYC(CHIRP_TX_CYC))
   i_snooze_wake_ctrl_asserts (.clk_i, .resetn_i, .ce_i, .address_i, .write_i, .writedata_i, .byteenable_i,
   .waitrequest_o, .line_level_i, .int_clk_en_o, .interrupt_out_n_o, .transceiver_speed_select_o,
   .termination_select_o, .transceiver_operating_select_o, .tx_valid_o, .tx_data_o);

// ==== dv/tb_usb_device_snooze_wake_resume.sv ====
// Purpose : runs snooze reset, chirp handshake and remote wakeup resume
// Assumes : short PLL and chirp counts, port model on the line
// Notes   : register expectations come from a small model in the bench
`timescale 1ns/1ps
module tb_usb_device_snooze_wake_resume;
   import snooze_wake_pkg::*;
   localparam int PLL_W = 10;
   localparam int CHIRP_W = 20;
   logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, rd_en = 1'b0, wr_en = 1'b0, clk_en, irq_n, xcvr, term, tx_valid, bdd;
   logic waitreq;
   logic [3:0] address = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] port_mode = 2'd0, line, opsel;
   logic [7:0] tx_data;
   int fails = 0, cmp_count = 0, seed = 32'hc03c, n, m_ctrl = 0, m_flags = 0, tx_len = 0;
   int tx_q[$];
   always #20 clk = ~clk;
   // device under test and the far side port
   snooze_wake_ctrl #(.PLL_WAIT_CYC(PLL_W), .CHIRP_TX_CYC(CHIRP_W)) i_snooze_wake_ctrl (.clk_i(clk),
      .resetn_i(resetn), .ce_i(ce), .address_i(address), .read_i(rd_en), .write_i(wr_en), .writedata_i(wdata),
      .byteenable_i(4'hf), .readdata_o(rdata), .waitrequest_o(waitreq), .line_level_i(line), .int_clk_en_o(clk_en),
      .interrupt_out_n_o(irq_n), .transceiver_speed_select_o(xcvr), .termination_select_o(term),
      .transceiver_operating_select_o(opsel), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .bus_detect_disable_o(bdd));
   usb_port_model i_usb_port_model (.clk_i(clk), .resetn_i(resetn), .mode_i(port_mode), .tx_valid_i(tx_valid),
      .line_o(line));
   // records the length of every transmit burst
   always @(posedge clk) begin
      if (tx_valid === 1'b1) tx_len++;
      else if (tx_len != 0) begin
         tx_q.push_back(tx_len);
         tx_len = 0;
      end
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk);
      address <= a;
      wdata   <= d;
      wr_en   <= wr;
      rd_en   <= !wr;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (waitreq !== 1'b0 && k < 50);
      q = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      if (k >= 50) begin
         chk("bus_ack", 1'b0, 1'b1);
         end_of_test();
      end
      if (wr && a == ADDR_CTRL) m_ctrl = d & 32'h14;
      if (wr && a == ADDR_FLAGS) m_flags = m_flags & ~d;
   endtask
   // bounded wait: 0 interrupt low, 1 clock enabled, 2 transmit on
   task automatic wait_for(input int sel, input int bound, output int cnt);
      logic hit;
      cnt = 0;
      hit = 1'b0;
      while (!hit && cnt < bound) begin
         @(posedge clk);
         cnt++;
         hit = (sel == 0) ? (irq_n === 1'b0) : ((sel == 1) ? (clk_en === 1'b1) : (tx_valid === 1'b1));
      end
      if (!hit) begin
         chk("wait_done", sel, 32'hff);
         end_of_test();
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      bus(0, ADDR_STATUS, 0, rd);
      chk("status_rst", {rd[9:6], rd[4:0]}, {4'b0011, LINE_J, PM_CODE_ACTIVE});
      bus(1, 4'h2, $random(seed), rd);
      bus(0, 4'h2, 0, rd);
      chk("unmapped", rd, 0);
      // bus reset while snoozing
      bus(1, ADDR_ENABLE, 32'h1f, rd);
      bus(1, ADDR_CTRL, 32'h2, rd);
      repeat (3) @(posedge clk);
      chk("clk_en_snooze", clk_en, 1'b0);
      ce        <= 1'b0;
      port_mode <= 2'd1;
      repeat (12) @(posedge clk);
      chk("ce_freeze", irq_n, 1'b1);
      ce <= 1'b1;
      wait_for(0, 40, n);
      m_flags = m_flags | 1;
      bus(0, ADDR_FLAGS, 0, rd);
      chk("flags", rd[2:0], m_flags);
      bus(0, ADDR_STATUS, 0, rd);
      chk("reset_seen", {rd[4:3], rd[2:0]}, {LINE_SE0, PM_CODE_SNOOZE});
      bus(1, ADDR_CTRL, 32'h1, rd);
      bus(0, ADDR_STATUS, 0, rd);
      chk("pll_state", rd[2:0], PM_CODE_PLL);
      wait_for(1, PLL_W + 20, n);
      chk("pll_time", n >= PLL_W - 4, 1'b1);
      bus(0, ADDR_CTRL, 0, rd);
      chk("ctrl", rd[5:0], m_ctrl);
      chk("irq_held", irq_n, 1'b0);
      bus(1, ADDR_FLAGS, 32'h1, rd);
      repeat (2) @(posedge clk);
      chk("irq_clear", irq_n, 1'b1);
      // chirp handshake after bus detect is disabled
      port_mode <= 2'd2;
      bus(1, ADDR_CTRL, 32'h4, rd);
      @(posedge clk);
      chk("det_dis", bdd, 1'b1);
      bus(1, ADDR_CTRL, 32'hc, rd);
      wait_for(0, CHIRP_W + 300, n);
      chk("chirp_len", (tx_q.size() > 0) ? tx_q.pop_front() : 0, CHIRP_W);
      m_flags = m_flags | 2;
      bus(0, ADDR_STATUS, 0, rd);
      chk("hs_mode", rd[7:5], 3'b000);
      bus(0, ADDR_CTRL, 0, rd);
      chk("ctrl", rd[5:0], m_ctrl);
      bus(0, ADDR_FLAGS, 0, rd);
      chk("flags", rd[2:0], m_flags);
      bus(1, ADDR_FLAGS, 32'h2, rd);
      port_mode <= 2'd0;
      // remote wakeup from snooze with HS saved
      bus(1, ADDR_ENABLE, 32'h1c, rd);
      bus(1, ADDR_CTRL, 32'h6, rd);
      bus(0, ADDR_STATUS, 0, rd);
      chk("saved_hs", {rd[5], rd[2:0]}, {SPEED_HS, PM_CODE_SNOOZE});
      repeat (20) @(posedge clk);
      bus(1, ADDR_CTRL, 32'h5, rd);
      wait_for(1, PLL_W + 20, n);
      port_mode <= 2'd3;
      bus(1, ADDR_CTRL, 32'h14, rd);
      wait_for(2, 10, n);
      chk("resume_tx", {opsel, tx_data}, {OPM_NOSTUF, 8'h00});
      repeat (20 + ($random(seed) & 15)) @(posedge clk);
      bus(1, ADDR_CTRL, 32'h4, rd);
      bus(0, ADDR_STATUS, 0, rd);
      chk("echo_k", rd[4:3], LINE_K);
      bus(1, ADDR_CTRL, 32'h24, rd);
      wait_for(0, 400, n);
      m_flags = m_flags | 4;
      bus(0, ADDR_STATUS, 0, rd);
      chk("restored", rd[7:6], 2'b00);
      bus(0, ADDR_CTRL, 0, rd);
      chk("ctrl", rd[5:0], m_ctrl);
      bus(0, ADDR_FLAGS, 0, rd);
      chk("flags", rd[2:0], m_flags);
      end_of_test();
   end
endmodule
